// file: core/region_flash_dev.sv
// Contract
// [RL1] three independent 1024-byte security regions
// [RL2] erase and program need write unlock latch
// [RL3] erase frame: 44H plus three address bytes
// [RL4] erase only if frame ends after address
// [RL5] erase busy flag high until cycle ends
// [RL6] latch cleared during erase or program cycle
// [RL7] locked region ignores erase and program
// [RL8] region address decode and byte offset
// [RL9] program: 42H, address, data; then busy
// [RL10] program stays within one 256-byte page
// [RL11] read: 48H, address, dummy, then data
// [RL12] read starts anywhere, address increments
// [RL13] read offset wraps 3FFH to 000H
// [RL14] reset aborts work, clears volatile state
// [RL15] reset is 66H frame then 99H frame
// [RL16] recovery window refuses all commands
// [RL17] host checks busy and suspend first
// [RL18] suspend refuses region erase or program; code refuses program only while SUSPENDED[0] is set
// [RL19] reset valid only right after enable
`timescale 1ns/1ns
module region_flash_dev
  import region_flash_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYCLES_DEF, // region_erase_time in cycles
  parameter int PROG_CYCLES  = PROG_CYCLES_DEF,  // page_program_time in cycles
  parameter int RST_E_CYCLES = RST_E_CYCLES_DEF  // recovery after erase abort
) (
  input  wire logic       CLK,          // system clock
  input  wire logic       SYS_RST,      // async reset
  spi_link_if.dev         LINK,         // serial link
  input  wire logic [2:0] LOCK_BITS,    // region_lock_bits
  input  wire logic [1:0] SUSP_SET,     // pulse: set suspended flags
  output logic            BUSY,         // cycle_in_progress_flag
  output logic            UNLOCK_LATCH, // write_unlock_latch
  output logic [1:0]      SUSPENDED,    // suspended_flags_pair
  output logic            RECOVERING    // reset recovery window
);

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ERASE = 4'b0010,
    ST_PROG  = 4'b0100,
    ST_RECOV = 4'b1000
  } state_t;

  // region select: {valid, index}
  function automatic logic [2:0] region_of(input logic [23:0] a);
    logic ok;
    ok = (a[23:16] == 8'h00) && (a[11:10] == 2'b00);
    if (ok && a[15:13] == 3'b000) region_of = 3'b100;
    else if (ok && a[15:12] == 4'h2) region_of = 3'b101;
    else if (ok && a[15:12] == 4'h3) region_of = 3'b110;
    else region_of = 3'b000;
  endfunction

  logic [1:0]   cs_sync_q;
  logic [1:0]   sck_sync_q;
  logic [1:0]   mosi_sync_q;
  logic         cs_p_q;
  logic         sck_p_q;
  logic [6:0]   sr_q;
  logic [2:0]   bit_q;
  logic [11:0]  byte_q;
  logic [7:0]   op_q;
  logic [23:0]  addr_q;
  logic [7:0]   out_q;
  logic         miso_q;
  state_t       state_q;
  logic [31:0]  timer_q;
  logic [10:0]  walk_q;
  logic [3:0]   cyc_q;
  logic         latch_q;
  logic         arm_q;
  logic [1:0]   susp_q;
  logic [255:0] pmask_q;
  logic [7:0]   mem  [0:MEM_BYTES-1];
  logic [7:0]   pbuf [0:PAGE_BYTES-1];

  wire        cs_n_s    = cs_sync_q[1];
  wire        active    = !cs_n_s;
  wire        sck_rise  = active && sck_sync_q[1] && !sck_p_q;
  wire        sck_fall  = active && !sck_sync_q[1] && sck_p_q;
  wire        cs_rise   = cs_n_s && !cs_p_q;
  wire        cs_fall   = !cs_n_s && cs_p_q;
  wire [7:0]  in_byte   = {sr_q, mosi_sync_q[1]};
  wire        byte_done = sck_rise && (bit_q == 3'd7);
  wire [7:0]  cur_op    = (byte_q == 12'h000) ? in_byte : op_q;
  wire        in_hdr    = (byte_q >= 12'h001) && (byte_q < 12'(HDR_BYTES));
  wire        in_data   = (byte_q >= 12'(HDR_BYTES));
  wire        idle      = (state_q == ST_IDLE);
  wire        recov     = (state_q == ST_RECOV);
  wire        busy      = (state_q == ST_ERASE) || (state_q == ST_PROG);

  // address decode of the current frame
  // [RL8] region decode
  wire [2:0]  sel       = region_of(addr_q);
  wire        sel_ok    = sel[2];
  // [RL7] lock gating
  wire        locked    = LOCK_BITS[sel[1:0]];
  wire [11:0] rd_index  = {sel[1:0], addr_q[9:0]};
  wire [7:0]  status    = {4'h0, susp_q[1], susp_q[0], latch_q, busy};

  // read path: status or region byte, loaded at each byte boundary
  // [RL11] data after dummy
  wire        rd_region = (cur_op == OP_REGION_READ) && in_data;
  wire        rd_status = (cur_op == OP_READ_STATUS);
  wire        rd_load   = byte_done && !recov && (rd_region || rd_status);
  wire [7:0]  rd_byte   = rd_status ? status : (sel_ok ? mem[rd_index] : 8'hFF);

  // program data capture into the page buffer, only while idle
  wire        pb_we     = byte_done && idle && (op_q == OP_REGION_PROG) && in_data;

  // frame end decode
  wire        framed    = cs_rise && (bit_q == 3'd0);
  wire        one_byte  = framed && (byte_q == 12'h001);
  wire        write_unlock_cmd_go   = one_byte && idle && (op_q == OP_WRITE_UNLOCK);
  // [RL4] exact erase frame
  wire        erase_len = framed && (byte_q == 12'(HDR_BYTES));
  // [RL9] at least one data byte
  wire        prog_len  = framed && (byte_q > 12'(HDR_BYTES));
  // [RL2] latch required
  wire        may_write = idle && latch_q && sel_ok && !locked;
  // [RL18] suspend refusal
  wire        erase_go  = erase_len && may_write && (op_q == OP_REGION_ERASE)
                          && (susp_q == 2'b00);
  wire        prog_go   = prog_len && may_write && (op_q == OP_REGION_PROG) && !susp_q[0];
  // [RL19] reset needs armed enable
  wire        reset_go  = one_byte && !recov && arm_q && (op_q == OP_RESET);

  // self-timed cycle memory writes
  // [RL1] per-region erase walk
  wire        er_we     = (state_q == ST_ERASE) && (walk_q < 11'(REGION_BYTES));
  // [RL10] one page per program
  wire        pg_we     = (state_q == ST_PROG) && (walk_q < 11'(PAGE_BYTES))
                          && pmask_q[walk_q[7:0]];
  wire        mem_we    = er_we || pg_we;
  wire [11:0] mem_wa    = er_we ? {cyc_q[3:2], walk_q[9:0]} : {cyc_q, walk_q[7:0]};
  wire [7:0]  mem_wd    = er_we ? 8'hFF : (mem[mem_wa] & pbuf[walk_q[7:0]]);

  // two-flop synchronisers plus edge history
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cs_sync_q   <= 2'b11;
      sck_sync_q  <= 2'b00;
      mosi_sync_q <= 2'b00;
      cs_p_q      <= 1'b1;
      sck_p_q     <= 1'b0;
    end else begin
      cs_sync_q   <= {cs_sync_q[0], LINK.cs_n};
      sck_sync_q  <= {sck_sync_q[0], LINK.sck};
      mosi_sync_q <= {mosi_sync_q[0], LINK.mosi};
      cs_p_q      <= cs_sync_q[1];
      sck_p_q     <= sck_sync_q[1];
    end
  end

  // input shifter, opcode and address capture
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sr_q   <= 7'h00;
      bit_q  <= 3'd0;
      byte_q <= 12'h000;
      op_q   <= 8'h00;
      addr_q <= 24'h000000;
    end else if (!active) begin
      bit_q  <= 3'd0;
      byte_q <= 12'h000;
    end else if (sck_rise) begin
      sr_q  <= in_byte[6:0];
      bit_q <= bit_q + 3'd1;
      if (byte_done && byte_q != 12'hFFF) byte_q <= byte_q + 12'h001;
      if (byte_done && byte_q == 12'h000) op_q <= in_byte;
      if (byte_done && in_hdr) addr_q <= {addr_q[15:0], in_byte};
      // [RL12] [RL13] increment with wrap
      else if (rd_load && rd_region) addr_q[9:0] <= addr_q[9:0] + 10'h001;
      // [RL10] column wraps in page
      else if (pb_we) addr_q[7:0] <= addr_q[7:0] + 8'h01;
    end
  end

  // output shifter, bit changes on link clock fall
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      out_q  <= 8'h00;
      miso_q <= 1'b0;
    end else if (!active) begin
      out_q  <= 8'h00;
      miso_q <= 1'b0;
    end else if (rd_load) begin
      out_q <= rd_byte;
    end else if (sck_fall) begin
      miso_q <= out_q[7];
      out_q  <= {out_q[6:0], 1'b0};
    end
  end

  // cycle sequencer and timer
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q <= ST_IDLE;
      timer_q <= 32'h00000000;
      walk_q  <= 11'h000;
      cyc_q   <= 4'h0;
    // [RL14] [RL16] abort and recover
    end else if (reset_go) begin
      state_q <= ST_RECOV;
      timer_q <= (state_q == ST_ERASE) ? 32'(RST_E_CYCLES - 1) : 32'(RST_CYCLES - 1);
    // [RL5] erase cycle start
    end else if (erase_go) begin
      state_q <= ST_ERASE;
      timer_q <= 32'(ERASE_CYCLES - 1);
      walk_q  <= 11'h000;
      cyc_q   <= {sel[1:0], 2'b00};
    // [RL9] program cycle start
    end else if (prog_go) begin
      state_q <= ST_PROG;
      timer_q <= 32'(PROG_CYCLES - 1);
      walk_q  <= 11'h000;
      cyc_q   <= {sel[1:0], addr_q[9:8]};
    end else if (!idle) begin
      if (walk_q != 11'(REGION_BYTES)) walk_q <= walk_q + 11'h001;
      if (timer_q == 32'h00000000) state_q <= ST_IDLE;
      else timer_q <= timer_q - 32'h00000001;
    end
  end

  // latch, reset arming and suspend flags
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      latch_q <= 1'b0;
      arm_q   <= 1'b0;
      susp_q  <= 2'b00;
    end else begin
      // [RL6] [RL14] latch clear
      if (reset_go || erase_go || prog_go) latch_q <= 1'b0;
      else if (write_unlock_cmd_go) latch_q <= 1'b1;
      // [RL19] arm on complete enable frame
      if (framed && byte_q != 12'h000) arm_q <= one_byte && !recov
                                               && (op_q == OP_RESET_ENABLE);
      // [RL14] suspend cleared, set wins
      susp_q <= (susp_q & ~{2{reset_go}}) | SUSP_SET;
    end
  end

  // page buffer byte mask, cleared at each idle frame start
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) pmask_q <= '0;
    else if (cs_fall && idle) pmask_q <= '0;
    else if (pb_we) pmask_q[addr_q[7:0]] <= 1'b1;
  end

  // storage arrays
  always_ff @(posedge CLK) begin
    if (mem_we) mem[mem_wa] <= mem_wd;
    if (pb_we) pbuf[addr_q[7:0]] <= in_byte;
  end

  // outputs
  assign LINK.miso    = miso_q;
  assign BUSY         = busy;
  assign UNLOCK_LATCH = latch_q;
  assign SUSPENDED    = susp_q;
  assign RECOVERING   = recov;

endmodule // region_flash_dev

// file: core/region_flash_host.sv
`timescale 1ns/1ns
module region_flash_host
  import region_flash_pkg::*;
#(
  parameter int SCK_HALF = SCK_HALF_DEF, // cycles per link clock half
  parameter int CS_GAP   = CS_GAP_DEF,   // cycles select stays high
  parameter int RX_DEPTH = 2             // receive buffer entries
) (
  input  wire logic        CLK,     // system clock
  input  wire logic        SYS_RST, // async reset
  input  wire logic        PSEL,    // apb select
  input  wire logic        PENABLE, // apb access phase
  input  wire logic        PWRITE,  // apb direction
  input  wire logic [7:0]  PADDR,   // apb byte address
  input  wire logic [31:0] PWDATA,  // apb write data
  output logic      [31:0] PRDATA,  // apb read data
  output logic             PREADY,  // apb ready
  output logic             PSLVERR, // apb error
  spi_link_if.host         LINK     // serial link
);

  localparam int PW = $clog2(RX_DEPTH);

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_LOW  = 4'b0010,
    H_HIGH = 4'b0100,
    H_GAP  = 4'b1000
  } hstate_t;

  hstate_t     st_q;
  logic        tx_v_q;
  logic [7:0]  tx_q;
  logic        tx_last_q;
  logic [7:0]  sh_q;
  logic [6:0]  rx_sr_q;
  logic [2:0]  bit_q;
  logic [15:0] div_q;
  logic        last_q;
  logic        cs_n_q;
  logic        sck_q;
  logic        mosi_q;
  logic [1:0]  miso_sync_q;
  logic [7:0]  fmem [0:RX_DEPTH-1];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [PW:0] cnt_q;
  logic [31:0] prdata_q;

  // apb decode
  wire sel_tx   = (PADDR == REG_TX);
  wire sel_rx   = (PADDR == REG_RX);
  wire sel_st   = (PADDR == REG_STAT);
  wire setup    = PSEL && !PENABLE;
  wire access   = PSEL && PENABLE;
  wire tx_stall = PWRITE && sel_tx && tx_v_q;
  wire tx_take  = access && PWRITE && sel_tx && !tx_v_q;

  // receive buffer flags, back-pressure stops new bytes
  wire       rx_v    = (cnt_q != '0);
  wire       rx_full = (cnt_q == (PW+1)'(RX_DEPTH));
  wire       rx_pop  = access && !PWRITE && sel_rx && prdata_q[RX_VALID];
  wire [7:0] rx_byte = {rx_sr_q, miso_sync_q[1]};
  wire       div_end = (div_q == 16'h0000);
  wire       push    = (st_q == H_HIGH) && div_end && (bit_q == 3'd7);
  wire       start   = (st_q == H_IDLE) && tx_v_q && !rx_full;
  wire       link_bz = (st_q != H_IDLE) || tx_v_q || !cs_n_q;

  // read data captured in setup phase
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) prdata_q <= 32'h00000000;
    else if (setup && sel_rx) prdata_q <= {23'h000000, rx_v, fmem[rp_q]};
    else if (setup && sel_st) prdata_q <= {29'h00000000, rx_full, rx_v, link_bz};
    else if (setup) prdata_q <= 32'h00000000;
  end

  // transmit holding register
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tx_v_q    <= 1'b0;
      tx_q      <= 8'h00;
      tx_last_q <= 1'b0;
    end else if (tx_take) begin
      tx_v_q    <= 1'b1;
      tx_q      <= PWDATA[7:0];
      tx_last_q <= PWDATA[TX_LAST];
    end else if (start) begin
      tx_v_q <= 1'b0;
    end
  end

  // receive buffer pointers and storage
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (rx_pop) rp_q <= rp_q + 1'b1;
      if (push && !rx_pop) cnt_q <= cnt_q + 1'b1;
      else if (rx_pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (push) fmem[wp_q] <= rx_byte;
  end

  // miso synchroniser
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) miso_sync_q <= 2'b00;
    else miso_sync_q <= {miso_sync_q[0], LINK.miso};
  end

  // link engine: mode 0, clock made by dividing CLK
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_q <= H_IDLE;
      sh_q <= 8'h00;
      rx_sr_q <= 7'h00;
      bit_q <= 3'd0;
      div_q <= 16'h0000;
      last_q <= 1'b0;
      cs_n_q <= 1'b1;
      sck_q <= 1'b0;
      mosi_q <= 1'b0;
    end else begin
      if (!div_end) div_q <= div_q - 16'h0001;
      unique case (st_q)
        H_IDLE: if (start) begin
          // [RL3] [RL15] frame opens on first byte
          cs_n_q <= 1'b0;
          mosi_q <= tx_q[7];
          sh_q <= {tx_q[6:0], 1'b0};
          last_q <= tx_last_q;
          bit_q <= 3'd0;
          div_q <= 16'(SCK_HALF - 1);
          st_q <= H_LOW;
        end
        H_LOW: if (div_end) begin
          sck_q <= 1'b1;
          div_q <= 16'(SCK_HALF - 1);
          st_q <= H_HIGH;
        end
        H_HIGH: if (div_end) begin
          sck_q <= 1'b0;
          rx_sr_q <= rx_byte[6:0];
          div_q <= 16'(SCK_HALF - 1);
          if (bit_q != 3'd7) begin
            bit_q <= bit_q + 3'd1;
            mosi_q <= sh_q[7];
            sh_q <= {sh_q[6:0], 1'b0};
            st_q <= H_LOW;
          end else if (last_q) begin
            // [RL3] [RL15] select rises after last bit
            cs_n_q <= 1'b1;
            div_q <= 16'(CS_GAP - 1);
            st_q <= H_GAP;
          end else begin
            st_q <= H_IDLE;
          end
        end
        H_GAP: if (div_end) st_q <= H_IDLE;
      endcase
    end
  end

  // apb answers
  // [RL17] status exposes link activity
  assign PRDATA    = prdata_q;
  assign PREADY    = !tx_stall;
  assign PSLVERR   = access && !(sel_tx || sel_rx || sel_st);
  assign LINK.cs_n = cs_n_q;
  assign LINK.sck  = sck_q;
  assign LINK.mosi = mosi_q;

endmodule // region_flash_host

// file: core/region_flash_pkg.sv
package region_flash_pkg;

  // timing base
  localparam int CLK_MHZ          = 125;
  localparam int T_RST_US         = 30;
  localparam int T_RST_E_US       = 12000;
  localparam int RST_CYCLES       = T_RST_US * CLK_MHZ;
  localparam int RST_E_CYCLES_DEF = T_RST_E_US * CLK_MHZ;
  localparam int ERASE_CYCLES_DEF = 2048;
  localparam int PROG_CYCLES_DEF  = 512;

  // region geometry
  localparam int REGIONS      = 3;
  localparam int REGION_BYTES = 1024;
  localparam int PAGE_BYTES   = 256;
  localparam int MEM_BYTES    = REGIONS * REGION_BYTES;
  localparam int HDR_BYTES    = 4;

  // opcodes
  localparam logic [7:0] OP_READ_STATUS  = 8'h05;
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] OP_REGION_PROG  = 8'h42;
  localparam logic [7:0] OP_REGION_ERASE = 8'h44;
  localparam logic [7:0] OP_REGION_READ  = 8'h48;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET        = 8'h99;

  // status byte fields
  localparam int STAT_BUSY       = 0;
  localparam int STAT_LATCH      = 1;
  localparam int STAT_SUSP_PROG  = 2;
  localparam int STAT_SUSP_ERASE = 3;

  // controller register map
  localparam logic [7:0] REG_TX     = 8'h00;
  localparam logic [7:0] REG_RX     = 8'h04;
  localparam logic [7:0] REG_STAT   = 8'h08;
  localparam int         TX_LAST    = 8;
  localparam int         RX_VALID   = 8;
  localparam int         ST_LINK    = 0;
  localparam int         ST_RXV     = 1;
  localparam int         ST_RXFULL  = 2;

  // controller link timing
  localparam int SCK_HALF_DEF = 10;
  localparam int CS_GAP_DEF   = 10;

endpackage

// file: core/spi_link_if.sv
`timescale 1ns/1ns
// serial link between controller and flash
interface spi_link_if;
  logic cs_n;  // chip select, low active
  logic sck;   // link clock, idles low
  logic mosi;  // controller to flash
  logic miso;  // flash to controller
  modport host (output cs_n, output sck, output mosi, input miso);
  modport dev  (input cs_n, input sck, input mosi, output miso);
endinterface

// file: sim/region_flash_asserts.sv
`timescale 1ns/1ns
module region_flash_asserts
  import region_flash_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYCLES_DEF, // erase span
  parameter int PROG_CYCLES  = PROG_CYCLES_DEF,  // program span
  parameter int RST_E_CYCLES = RST_E_CYCLES_DEF  // recovery after erase abort
) (
  input wire logic       CLK,          // system clock
  input wire logic       SYS_RST,      // async reset
  input wire logic       cs_n,         // link select
  input wire logic       sck,          // link clock
  input wire logic       miso,         // device data
  input wire logic       BUSY,         // cycle flag
  input wire logic       UNLOCK_LATCH, // write unlock latch
  input wire logic [1:0] SUSPENDED,    // suspend flags
  input wire logic       RECOVERING    // recovery window
);
  int busy_cnt_q;
  int rec_cnt_q;

  // length of the running busy and recovery spans
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      busy_cnt_q <= 0;
      rec_cnt_q  <= 0;
    end else begin
      busy_cnt_q <= BUSY ? busy_cnt_q + 1 : 0;
      rec_cnt_q  <= RECOVERING ? rec_cnt_q + 1 : 0;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  property p_latch_spent; $rose(BUSY) |-> $past(UNLOCK_LATCH) && !UNLOCK_LATCH; endproperty
  a_latch_spent: assert property (p_latch_spent)
    else $error("cycle started without spending the latch");
  property p_start_at_cs; $rose(BUSY) |-> cs_n && $past(cs_n); endproperty
  a_start_at_cs: assert property (p_start_at_cs)
    else $error("cycle started inside a frame");
  property p_busy_len;
    $fell(BUSY) && !RECOVERING |-> busy_cnt_q == ERASE_CYCLES || busy_cnt_q == PROG_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy span has the wrong length");
  property p_rec_len; $fell(RECOVERING) |-> rec_cnt_q == RST_CYCLES || rec_cnt_q == RST_E_CYCLES;
  endproperty
  a_rec_len: assert property (p_rec_len)
    else $error("recovery span has the wrong length");
  property p_reset_clears; $rose(RECOVERING) |-> !BUSY && !UNLOCK_LATCH && SUSPENDED == 2'h0;
  endproperty
  a_reset_clears: assert property (p_reset_clears)
    else $error("reset left volatile state behind");
  property p_rec_idle; RECOVERING |-> !BUSY && !UNLOCK_LATCH; endproperty
  a_rec_idle: assert property (p_rec_idle)
    else $error("command acted during recovery");
  property p_rec_quiet; RECOVERING && $past(RECOVERING, 3) |-> !miso; endproperty
  a_rec_quiet: assert property (p_rec_quiet)
    else $error("device answered during recovery");
  property p_sck_idle; cs_n |-> !sck; endproperty
  a_sck_idle: assert property (p_sck_idle)
    else $error("link clock high outside a frame");
  property p_cs_gap; $rose(cs_n) |-> cs_n [*8]; endproperty
  a_cs_gap: assert property (p_cs_gap)
    else $error("select gap too short");

  // main scenarios reached
  c_cycle_done: cover property ($fell(BUSY) && !RECOVERING);
  c_abort: cover property ($fell(BUSY) && RECOVERING);
  c_recovered: cover property ($fell(RECOVERING));
endmodule // region_flash_asserts

// file: sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import region_flash_pkg::*;
  localparam int ERASE_N = 1100;
  localparam int PROG_N  = 300;
  localparam int RSTE_N  = 200;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic        busy, latch, recovering;
  logic [7:0]  paddr, wop;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  lock_bits;
  logic [1:0]  susp_set, suspended;
  logic [7:0]  mem [0:3071];
  logic [7:0]  txb [0:31];
  logic [7:0]  rxb [0:31];
  int          seed, num_errors, comparisons, r, i, k, off, wbits;
  spi_link_if  link ();

  region_flash_host region_flash_host_inst (.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .LINK(link.host));
  region_flash_dev #(.ERASE_CYCLES(ERASE_N), .PROG_CYCLES(PROG_N), .RST_E_CYCLES(RSTE_N))
    region_flash_dev_inst (.CLK(clk), .SYS_RST(sys_rst), .LINK(link.dev),
    .LOCK_BITS(lock_bits), .SUSP_SET(susp_set), .BUSY(busy), .UNLOCK_LATCH(latch),
    .SUSPENDED(suspended), .RECOVERING(recovering));
  region_flash_asserts #(.ERASE_CYCLES(ERASE_N), .PROG_CYCLES(PROG_N), .RST_E_CYCLES(RSTE_N))
    region_flash_asserts_inst (.CLK(clk), .SYS_RST(sys_rst), .cs_n(link.cs_n),
    .sck(link.sck), .miso(link.miso), .BUSY(busy), .UNLOCK_LATCH(latch),
    .SUSPENDED(suspended), .RECOVERING(recovering));

  // system clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // shadow of the serial input, first byte taken on link clock rise
  always @(negedge link.cs_n) wbits = 0;
  always @(posedge link.sck) begin
    if (wbits < 8) wop = {wop[6:0], link.mosi};
    wbits++;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    if (num_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic frame(input int n);
    int j;
    for (j = 0; j < n; j++) begin
      apb(1'b1, REG_TX, {23'h0, j == n - 1, txb[j]});
      rd = 32'h0;
      while (rd[RX_VALID] !== 1'b1) apb(1'b0, REG_RX, 32'h0);
      rxb[j] = rd[7:0];
    end
    while (link.cs_n !== 1'b1) @(posedge clk);
    repeat (8) @(posedge clk);
    check("wire bits", wbits, 8 * n);
    check("wire opcode", wop, txb[0]);
    apb(1'b0, REG_STAT, 32'h0);
    check("link idle", rd, 32'h0);
  endtask

  task automatic cmd4(input logic [7:0] op, input logic [23:0] a, input int n);
    txb[0] = op;
    txb[1] = a[23:16];
    txb[2] = a[15:8];
    txb[3] = a[7:0];
    frame(n);
  endtask

  task automatic one(input logic [7:0] op);
    txb[0] = op;
    frame(1);
  endtask

  task automatic stat;
    txb[0] = OP_READ_STATUS;
    txb[1] = 8'h00;
    frame(2);
  endtask

  task automatic wait_clear(input logic rec);
    while ((rec ? recovering : busy) !== 1'b0) @(posedge clk);
  endtask

  function automatic logic [23:0] raddr(input int rg, input int o);
    return {8'h00, 4'(rg), 2'b00, 10'(o)};
  endfunction

  task automatic rd_chk(input logic [23:0] a, input int n);
    int j, b;
    b = a[13] ? (a[12] ? 2048 : 1024) : 0;
    txb[4] = 8'h00;
    cmd4(OP_REGION_READ, a, n + 5);
    for (j = 0; j < n; j++) begin
      check("read byte", rxb[5 + j], mem[b + ((a[9:0] + j) & 1023)]);
    end
  endtask

  // watchdog
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    seed = 23;
    num_errors = 0;
    comparisons = 0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lock_bits = 3'h0;
    susp_set = 2'h0;
    sys_rst = 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    apb(1'b0, 8'h0C, 32'h0);
    check("unmapped error", err, 1'b1);
    for (r = 1; r <= 3; r++) begin
      one(OP_WRITE_UNLOCK);
      check("latch set", latch, 1'b1);
      cmd4(OP_REGION_ERASE, raddr(r, $random(seed)), 4);
      stat();
      check("busy status", rxb[1], 8'h01);
      wait_clear(1'b0);
      stat();
      check("idle status", rxb[1], 8'h00);
      for (k = 0; k < 1024; k++) mem[(r - 1) * 1024 + k] = 8'hFF;
    end
    txb[4] = 8'h00;
    for (k = 0; k < 6; k++) begin
      lock_bits <= (k == 2 || k == 3) ? 3'h2 : 3'h0;
      susp_set <= (k == 5) ? 2'h2 : 2'h0;
      @(posedge clk);
      susp_set <= 2'h0;
      if (k != 0) one(OP_WRITE_UNLOCK);
      cmd4(k == 3 ? OP_REGION_PROG : OP_REGION_ERASE, k == 4 ? 24'h012000 : raddr(2, 0),
           (k == 1 || k == 3) ? 5 : 4);
      check("refused", busy, 1'b0);
    end
    // three status bytes queued before any drain: engine stalls on a full buffer
    for (k = 0; k < 3; k++) apb(1'b1, REG_TX, {23'h0, k == 2, OP_READ_STATUS});
    repeat (200) @(posedge clk);
    apb(1'b0, REG_STAT, 32'h0);
    check("full status", rd, 32'h7);
    for (k = 0; k < 3; k++) begin
      rd = 32'h0;
      while (rd[RX_VALID] !== 1'b1) apb(1'b0, REG_RX, 32'h0);
      check("drained byte", rd, k == 0 ? 32'h100 : 32'h10A);
    end
    for (r = 1; r <= 3; r++) begin
      off = (r == 3) ? 10'h3FD : ((($random(seed) & 3) << 8) | 8'hFD);
      for (i = 0; i < 5; i++) begin
        txb[4 + i] = $random(seed);
        mem[(r - 1) * 1024 + (off & 10'h300) + ((off + i) & 8'hFF)] &= txb[4 + i];
      end
      one(OP_WRITE_UNLOCK);
      cmd4(OP_REGION_PROG, raddr(r, off), 9);
      check("program busy", busy, 1'b1);
      wait_clear(1'b0);
      rd_chk(r == 1 ? {14'h0, 10'(off & 10'h300)} : raddr(r, off & 10'h300), 4);
      rd_chk(raddr(r, (off & 10'h300) + 8'hFC), 8);
    end
    susp_set <= 2'h1;
    @(posedge clk);
    susp_set <= 2'h0;
    one(OP_WRITE_UNLOCK);
    cmd4(OP_REGION_PROG, raddr(1, 0), 5);
    check("program in suspend", busy, 1'b0);
    one(OP_RESET);
    check("lone reset", recovering, 1'b0);
    one(OP_RESET_ENABLE);
    stat();
    check("status before reset", rxb[1], 8'h0E);
    one(OP_RESET);
    check("disarmed reset", recovering, 1'b0);
    one(OP_WRITE_UNLOCK);
    one(OP_RESET_ENABLE);
    one(OP_RESET);
    check("reset taken", {recovering, latch, suspended}, 4'h8);
    one(OP_WRITE_UNLOCK);
    check("unlock in recovery", latch, 1'b0);
    wait_clear(1'b1);
    one(OP_WRITE_UNLOCK);
    cmd4(OP_REGION_ERASE, raddr(2, 0), 4);
    one(OP_RESET_ENABLE);
    one(OP_RESET);
    check("erase aborted", {recovering, busy}, 2'h2);
    wait_clear(1'b1);
    rd_chk(raddr(3, 10'h3FC), 4);
    tally_and_finish();
  end
endmodule // tb_top
